// file: hw/supply_integrity_map.vh
// register offsets, field positions, reset values and delays of the supply integrity monitor
`ifndef SUPPLY_INTEGRITY_MAP_VH
`define SUPPLY_INTEGRITY_MAP_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SIM_OFS_CTRL       8'h00
`define SIM_OFS_IRQ_STAT   8'h04
`define SIM_OFS_IRQ_MASK   8'h08

// ----------------------------------------------------------------------------
// integrity_ctrl_status fields
// ----------------------------------------------------------------------------
`define SIM_CTRL_LEVEL     0
`define SIM_CTRL_IRQ_EN    1
`define SIM_CTRL_TOGGLE    2
`define SIM_CTRL_DET_EN    3
`define SIM_CTRL_THR_LO    4
`define SIM_CTRL_THR_HI    5
`define SIM_CTRL_LONG_DLY  6
`define SIM_CTRL_IN_RESET  7

// ----------------------------------------------------------------------------
// interrupt status / mask fields
// ----------------------------------------------------------------------------
`define SIM_IRQ_WARN       0
`define SIM_IRQ_LSR        1
`define SIM_IRQ_ILLOP      2
`define SIM_IRQ_W          3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SIM_RST_IRQ_EN     1'b0
`define SIM_RST_IRQ_STAT   3'h0
`define SIM_RST_IRQ_MASK   3'h0

// ----------------------------------------------------------------------------
// power-on reset delays in cpu cycles
// ----------------------------------------------------------------------------
`define SIM_POR_SHORT      13'h0100
`define SIM_POR_LONG       13'h1000

`endif

// file: hw/level_sync3.v
// three-flop pin synchroniser, output moves once stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module level_sync3 (
    input  wire hclk,      // cpu clock
    input  wire hresetn,   // async reset, active low
    input  wire clk_en,    // freezes state while low
    input  wire async_in,  // asynchronous level
    output reg  sync_out   // filtered synchronous level
);

    reg s1_r;
    reg s2_r;
    reg s3_r;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r     <= 1'b0;
            s2_r     <= 1'b0;
            s3_r     <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en) begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                sync_out <= s3_r;
            end
        end
    end

endmodule // level_sync3

`default_nettype wire

// file: hw/por_delay.v
// power-on reset delay counter, busy while held and for the selected count after
`timescale 1ns/10ps
`default_nettype none
`include "supply_integrity_map.vh"

module por_delay #(
    parameter        CW        = 13,
    parameter [12:0] SHORT_CNT = `SIM_POR_SHORT,
    parameter [12:0] LONG_CNT  = `SIM_POR_LONG
) (
    input  wire hclk,      // cpu clock
    input  wire hresetn,   // async reset, active low
    input  wire clk_en,    // freezes state while low
    input  wire hold,      // reset source present, reloads
    input  wire long_sel,  // selects the long delay
    output wire busy       // hold or delay still running
);

    reg [CW-1:0] cnt_r;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= {CW{1'b0}};
        end else if (clk_en) begin
            if (hold) begin
                cnt_r <= long_sel ? LONG_CNT[CW-1:0] : SHORT_CNT[CW-1:0];
            end else if (cnt_r != {CW{1'b0}}) begin
                cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    assign busy = hold | (cnt_r != {CW{1'b0}});

endmodule // por_delay

`default_nettype wire

// file: hw/supply_integrity_monitor.v
// supply integrity monitor: low-supply reset, supply warning and its ahb-lite registers
//
// How it works
// [R1] hold chip reset while supply below threshold; rise uses upper, fall lower
// [R2] threshold level low, medium or high from option bits, fixed while running
// [R3] low-supply detector acts only when its option bit enables it
// [R4] during low-supply reset the reset pin is driven low
// [R5] illegal opcode or prebyte pulse also raises a reset
// [R6] warning level readable as real-time status bit, writes ignored
// [R7] warning works only with the low-supply detector enabled
// [R8] warning thresholds follow the selected low-supply threshold level
// [R9] enabled warning interrupt fires on each warning level toggle; the code counts a toggle only while state_r is ST_RUN
// [R10] rising crossing inside the power-on delay gives no interrupt
// [R11] enabling while supply still low gives an immediate interrupt
// [R12] enabling after the rising crossing gives no immediate interrupt
// [R13] comparator outputs are synchronised before use
`timescale 1ns/10ps
`default_nettype none
`include "supply_integrity_map.vh"

module supply_integrity_monitor #(
    parameter [12:0] POR_SHORT = `SIM_POR_SHORT,
    parameter [12:0] POR_LONG  = `SIM_POR_LONG
) (
    input  wire        hclk,          // cpu clock, 40 MHz
    input  wire        hresetn,       // async reset, active low
    input  wire        clk_en,        // freezes all state while low
    // ahb-lite slave
    input  wire        hsel,          // slave select
    input  wire [7:0]  haddr,         // byte address
    input  wire [1:0]  htrans,        // transfer type
    input  wire        hwrite,        // write when high
    input  wire [2:0]  hsize,         // transfer size
    input  wire        hready,        // bus ready
    input  wire [31:0] hwdata,        // write data
    output wire        hreadyout,     // slave ready
    output wire        hresp,         // always okay
    output reg  [31:0] hrdata,        // read data
    // non-volatile option bits
    input  wire        opt_det_en,    // low-supply detector enable
    input  wire [1:0]  opt_level,     // threshold level 0 low 1 medium 2 high
    input  wire        opt_long_dly,  // long power-on delay
    // analog comparators, high = supply below
    input  wire        lsr_below_hi,  // below rising reset threshold
    input  wire        lsr_below_lo,  // below falling reset threshold
    input  wire        warn_below_hi, // below rising warning threshold
    input  wire        warn_below_lo, // below falling warning threshold
    output reg  [1:0]  threshold_sel, // level to both comparator pairs
    output reg         detector_on,   // comparators enabled
    // core
    input  wire        illegal_op,    // illegal opcode or prebyte pulse
    output reg         chip_reset,    // chip reset request, high active
    output wire        rst_pin_o,     // reset pin drive value
    output wire        rst_pin_oe_n,  // reset pin enable, low drives
    output wire        irq            // level interrupt
);

    // ------------------------------------------------------------------------
    // option capture after reset release
    // ------------------------------------------------------------------------
    reg       opt_taken_r;
    reg       det_en_r;
    reg       long_dly_r;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opt_taken_r   <= 1'b0;
            det_en_r      <= 1'b0;
            long_dly_r    <= 1'b1;
            threshold_sel <= 2'h0;
            detector_on   <= 1'b0;
        end else if (clk_en && !opt_taken_r) begin
            opt_taken_r   <= 1'b1;
            det_en_r      <= opt_det_en;                  // [R3]
            long_dly_r    <= opt_long_dly;
            threshold_sel <= opt_level;                   // [R2] [R8]
            detector_on   <= opt_det_en;
        end
    end

    // ------------------------------------------------------------------------
    // comparator synchronisers
    // ------------------------------------------------------------------------
    wire lsr_hi_s;
    wire lsr_lo_s;
    wire warn_hi_s;
    wire warn_lo_s;

    level_sync3 u_sync_lsr_hi (                           // [R13]
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clk_en   (clk_en),
        .async_in (lsr_below_hi),
        .sync_out (lsr_hi_s)
    );

    level_sync3 u_sync_lsr_lo (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clk_en   (clk_en),
        .async_in (lsr_below_lo),
        .sync_out (lsr_lo_s)
    );

    level_sync3 u_sync_warn_hi (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clk_en   (clk_en),
        .async_in (warn_below_hi),
        .sync_out (warn_hi_s)
    );

    level_sync3 u_sync_warn_lo (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clk_en   (clk_en),
        .async_in (warn_below_lo),
        .sync_out (warn_lo_s)
    );

    // ------------------------------------------------------------------------
    // low-supply hysteresis and reset sequencing
    // ------------------------------------------------------------------------
    localparam [1:0] ST_RESET = 2'b00;
    localparam [1:0] ST_DELAY = 2'b01;
    localparam [1:0] ST_RUN   = 2'b10;

    reg  [1:0] state_r;
    reg  [1:0] state_nxt;
    reg        low_r;
    reg        low_nxt;
    wire       dly_busy;
    wire       hold_src;

    // below-threshold flag with hysteresis, never set when disabled
    always @* begin
        low_nxt = low_r;
        if (!det_en_r) begin
            low_nxt = 1'b0;                               // [R3]
        end else if (low_r) begin
            low_nxt = lsr_hi_s;                           // [R1]
        end else begin
            low_nxt = lsr_lo_s;                           // [R1]
        end
    end

    assign hold_src = !opt_taken_r | low_r | illegal_op;  // [R5]

    por_delay #(
        .CW        (13),
        .SHORT_CNT (POR_SHORT),
        .LONG_CNT  (POR_LONG)
    ) u_por_delay (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clk_en   (clk_en),
        .hold     (hold_src),
        .long_sel (long_dly_r),
        .busy     (dly_busy)
    );

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: begin
                if (!hold_src) begin
                    state_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (hold_src) begin
                    state_nxt = ST_RESET;
                end else if (!dly_busy) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (hold_src) begin
                    state_nxt = ST_RESET;
                end
            end
            default: begin
                state_nxt = ST_RESET;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r    <= ST_RESET;
            low_r      <= 1'b0;
            chip_reset <= 1'b1;
        end else if (clk_en) begin
            state_r    <= state_nxt;
            low_r      <= low_nxt;
            chip_reset <= (state_nxt != ST_RUN);          // [R1] [R5]
        end
    end

    // open-drain reset pin, pulled low while reset is held
    assign rst_pin_o    = 1'b0;
    assign rst_pin_oe_n = ~chip_reset;                    // [R4]

    // ------------------------------------------------------------------------
    // supply warning level
    // ------------------------------------------------------------------------
    reg  warn_r;
    reg  warn_nxt;

    always @* begin
        warn_nxt = warn_r;
        if (!det_en_r) begin
            warn_nxt = 1'b0;                              // [R7]
        end else if (warn_r) begin
            warn_nxt = warn_hi_s;                         // [R8]
        end else begin
            warn_nxt = warn_lo_s;
        end
    end

    // ------------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------------
    reg        dp_wr_r;
    reg  [7:0] dp_addr_r;
    reg        irq_en_r;
    reg  [`SIM_IRQ_W-1:0] irq_stat_r;
    reg  [`SIM_IRQ_W-1:0] irq_mask_r;
    reg  [31:0] rd_nxt;
    wire        acc;
    wire        wr_ctrl;
    wire        wr_stat;
    wire        wr_mask;
    wire        en_rise;
    wire [`SIM_IRQ_W-1:0] ev;
    wire [`SIM_IRQ_W-1:0] w1c;

    assign acc       = hsel & htrans[1] & hready;
    assign hreadyout = clk_en;
    assign hresp     = 1'b0;

    assign wr_ctrl = dp_wr_r & (dp_addr_r == `SIM_OFS_CTRL);
    assign wr_stat = dp_wr_r & (dp_addr_r == `SIM_OFS_IRQ_STAT);
    assign wr_mask = dp_wr_r & (dp_addr_r == `SIM_OFS_IRQ_MASK);

    // interrupt enable written high while it was low, whatever the supply level
    assign en_rise = wr_ctrl & hwdata[`SIM_CTRL_IRQ_EN] & ~irq_en_r;

    // toggle only counts once out of reset and the power-on delay
    assign ev[`SIM_IRQ_WARN] = irq_en_r & (warn_nxt != warn_r) & (state_r == ST_RUN)  // [R9] [R10]
                             | en_rise & warn_r;          // [R11] [R12]
    assign ev[`SIM_IRQ_LSR]   = low_nxt & ~low_r;
    assign ev[`SIM_IRQ_ILLOP] = illegal_op;

    assign w1c = wr_stat ? hwdata[`SIM_IRQ_W-1:0] : {`SIM_IRQ_W{1'b0}};

    always @* begin
        rd_nxt = 32'h0000_0000;
        case (haddr)
            `SIM_OFS_CTRL: begin
                rd_nxt[`SIM_CTRL_LEVEL]    = warn_r;      // [R6]
                rd_nxt[`SIM_CTRL_IRQ_EN]   = irq_en_r;
                rd_nxt[`SIM_CTRL_TOGGLE]   = irq_stat_r[`SIM_IRQ_WARN];
                rd_nxt[`SIM_CTRL_DET_EN]   = det_en_r;
                rd_nxt[`SIM_CTRL_THR_LO]   = threshold_sel[0];
                rd_nxt[`SIM_CTRL_THR_HI]   = threshold_sel[1];
                rd_nxt[`SIM_CTRL_LONG_DLY] = long_dly_r;
                rd_nxt[`SIM_CTRL_IN_RESET] = chip_reset;
            end
            `SIM_OFS_IRQ_STAT: begin
                rd_nxt[`SIM_IRQ_W-1:0] = irq_stat_r;
            end
            `SIM_OFS_IRQ_MASK: begin
                rd_nxt[`SIM_IRQ_W-1:0] = irq_mask_r;
            end
            default: begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r    <= 1'b0;
            dp_addr_r  <= 8'h00;
            hrdata     <= 32'h0000_0000;
            irq_en_r   <= `SIM_RST_IRQ_EN;
            irq_stat_r <= `SIM_RST_IRQ_STAT;
            irq_mask_r <= `SIM_RST_IRQ_MASK;
            warn_r     <= 1'b0;
        end else if (clk_en) begin
            dp_wr_r   <= acc & hwrite;
            dp_addr_r <= haddr;
            if (acc && !hwrite) begin
                hrdata <= rd_nxt;
            end
            warn_r <= warn_nxt;
            if (wr_ctrl) begin
                irq_en_r <= hwdata[`SIM_CTRL_IRQ_EN];     // level bit not writable [R6]
            end
            if (wr_mask) begin
                irq_mask_r <= hwdata[`SIM_IRQ_W-1:0];
            end
            irq_stat_r <= (irq_stat_r & ~w1c) | ev;       // set wins over clear
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

endmodule // supply_integrity_monitor

`default_nettype wire

// file: sim/supply_integrity_properties.sv
// assertion checker bound to the supply integrity monitor ports
`timescale 1ns/10ps
`default_nettype none

module supply_integrity_properties #(
    parameter int POR_SHORT = 256
) (
    input wire logic        hclk,          // cpu clock
    input wire logic        hresetn,       // async reset, active low
    input wire logic        clk_en,        // run enable
    input wire logic        hsel,          // slave select
    input wire logic [1:0]  htrans,        // transfer type
    input wire logic        hwrite,        // write when high
    input wire logic        hready,        // bus ready
    input wire logic        hreadyout,     // slave ready
    input wire logic        hresp,         // response
    input wire logic [31:0] hrdata,        // read data
    input wire logic [1:0]  threshold_sel, // chosen level
    input wire logic        detector_on,   // comparators enabled
    input wire logic        lsr_below_hi,  // below rising reset threshold
    input wire logic        lsr_below_lo,  // below falling reset threshold
    input wire logic        illegal_op,    // illegal opcode pulse
    input wire logic        chip_reset,    // chip reset request
    input wire logic        rst_pin_o,     // reset pin value
    input wire logic        rst_pin_oe_n   // reset pin enable, low drives
);
    logic [1:0]  cap_r;
    logic [15:0] rst_cnt_r;

    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_r     <= 2'h0;
            rst_cnt_r <= 16'h0000;
        end else begin
            if (clk_en)
                cap_r <= {cap_r[0], 1'b1};
            if (!chip_reset)
                rst_cnt_r <= 16'h0000;
            else if (rst_cnt_r != 16'hffff)
                rst_cnt_r <= rst_cnt_r + 16'h0001;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence rd_taken;
        hsel && htrans[1] && hready && clk_en && !hwrite;
    endsequence
    sequence lo_held;
        (detector_on && lsr_below_lo)[*6];
    endsequence
    sequence hold_low;
        (detector_on && chip_reset && lsr_below_hi)[*6];
    endsequence

    a_pin_follows_reset: assert property (rst_pin_oe_n == !chip_reset && rst_pin_o == 1'b0)
        else $error("reset pin does not follow chip reset");
    a_illegal_resets: assert property (illegal_op |-> ##[1:2] chip_reset)
        else $error("illegal opcode gave no reset");
    a_low_supply_reset: assert property (lo_held |-> ##[0:3] chip_reset)
        else $error("low supply gave no reset");
    a_reset_holds_low: assert property (hold_low |=> chip_reset)
        else $error("reset released below rising threshold");
    a_no_reset_off: assert property (!detector_on && !illegal_op && !chip_reset |=> !chip_reset)
        else $error("reset raised with detector off");
    a_release_delay: assert property ($fell(chip_reset) |-> rst_cnt_r >= POR_SHORT)
        else $error("reset released before the delay");
    a_options_fixed: assert property (cap_r[1] |-> $stable(threshold_sel) && $stable(detector_on))
        else $error("option outputs changed while running");
    a_read_upper_zero: assert property (rd_taken |=> hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_resp_okay: assert property (hresp == 1'b0 && hreadyout == clk_en)
        else $error("bus response not okay");
endmodule // supply_integrity_properties

bind supply_integrity_monitor supply_integrity_properties #(.POR_SHORT(POR_SHORT)) u_props (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .threshold_sel(threshold_sel), .detector_on(detector_on), .lsr_below_hi(lsr_below_hi),
    .lsr_below_lo(lsr_below_lo), .illegal_op(illegal_op), .chip_reset(chip_reset),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n)
);

`default_nettype wire

// file: sim/supply_comparators.sv
// behavioural model of the analog supply comparators
`timescale 1ns/10ps
`default_nettype none

module supply_comparators (
    input  wire logic       hclk,          // cpu clock, paces idle noise
    input  wire logic [7:0] supply_lvl,    // supply in 50 mV steps
    input  wire logic [1:0] threshold_sel, // level chosen by the device
    input  wire logic       detector_on,   // comparators powered
    output logic            lsr_below_hi,  // below rising reset threshold
    output logic            lsr_below_lo,  // below falling reset threshold
    output logic            warn_below_hi, // below rising warning threshold
    output logic            warn_below_lo  // below falling warning threshold
);
    logic [7:0] base;
    logic       noise_r = 1'b0;

    // unpowered comparators give no stable level
    always @(posedge hclk) begin
        noise_r <= ~noise_r;
    end

    assign base          = 8'h28 + 8'h0a * {6'h00, threshold_sel};
    assign lsr_below_lo  = detector_on ? (supply_lvl < base) : noise_r;
    assign lsr_below_hi  = detector_on ? (supply_lvl < base + 8'h02) : ~noise_r;
    assign warn_below_lo = detector_on ? (supply_lvl < base + 8'h04) : noise_r;
    assign warn_below_hi = detector_on ? (supply_lvl < base + 8'h06) : ~noise_r;
endmodule // supply_comparators

`default_nettype wire

// file: sim/tb_top.sv
// self-checking testbench for the supply integrity monitor
`timescale 1ns/10ps
`default_nettype none
`include "supply_integrity_map.vh"

module tb_top;
    localparam logic [12:0] POR_L = 13'h0020;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        opt_det_en = 1'b1;
    logic [1:0]  opt_level = 2'h1;
    logic        opt_long_dly = 1'b0;
    logic        illegal_op = 1'b0;
    logic [7:0]  supply_lvl = 8'h00;
    logic [7:0]  lv [3] = '{8'h3a, 8'h37, 8'h35};
    logic        ev [3] = '{1'b1, 1'b0, 1'b1};
    logic [31:0] rd;
    int          n;
    int          error_cnt = 0;
    int          cmp_count = 0;
    wire         hreadyout, hresp, chip_reset, rst_pin_o, rst_pin_oe_n, irq, detector_on;
    wire         lsr_hi, lsr_lo, warn_hi, warn_lo;
    wire [1:0]   threshold_sel;
    wire [31:0]  hrdata;

    initial begin
        forever #12.5 hclk = ~hclk;
    end

    supply_integrity_monitor #(.POR_SHORT(13'h0008), .POR_LONG(POR_L)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .opt_det_en(opt_det_en),
        .opt_level(opt_level), .opt_long_dly(opt_long_dly), .lsr_below_hi(lsr_hi),
        .lsr_below_lo(lsr_lo), .warn_below_hi(warn_hi), .warn_below_lo(warn_lo),
        .threshold_sel(threshold_sel), .detector_on(detector_on), .illegal_op(illegal_op),
        .chip_reset(chip_reset), .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n), .irq(irq)
    );

    supply_comparators u_cmp (
        .hclk(hclk), .supply_lvl(supply_lvl), .threshold_sel(threshold_sel),
        .detector_on(detector_on), .lsr_below_hi(lsr_hi), .lsr_below_lo(lsr_lo),
        .warn_below_hi(warn_hi), .warn_below_lo(warn_lo)
    );

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_ready();
        int k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            chk({31'h0, hreadyout}, 32'h0000_0001);
            end_of_test();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic wait_cr(input logic v);
        n = 0;
        while (chip_reset !== v && n < 300) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 300) begin
            chk({31'h0, chip_reset}, {31'h0, v});
            end_of_test();
        end
    endtask

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(negedge hclk);
        chk({31'h0, chip_reset}, 32'h0000_0001);
        chk({31'h0, rst_pin_oe_n}, 32'h0000_0000);
        chk({29'h0, detector_on, threshold_sel}, 32'h0000_0005);
        rchk(`SIM_OFS_IRQ_MASK, 32'h0000_0000);
        rchk(`SIM_OFS_IRQ_STAT, 32'h0000_0002);
        rchk(`SIM_OFS_CTRL, 32'h0000_0099);
        supply_lvl <= 8'h35;
        wait_cr(1'b0);
        wr(`SIM_OFS_IRQ_STAT, 32'h0000_0007);
        rchk(`SIM_OFS_CTRL, 32'h0000_0019);
        wr(`SIM_OFS_CTRL, 32'h0000_0002);
        rchk(`SIM_OFS_IRQ_STAT, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`SIM_OFS_IRQ_MASK, 32'h0000_0001);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0000_0001);
        rchk(`SIM_OFS_CTRL, 32'h0000_001f);
        wr(`SIM_OFS_IRQ_STAT, 32'h0000_0001);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk);
            supply_lvl <= lv[i];
            repeat (8) @(posedge hclk);
            rchk(`SIM_OFS_IRQ_STAT, {31'h0, ev[i]});
            wr(`SIM_OFS_IRQ_STAT, 32'h0000_0001);
        end
        wr(`SIM_OFS_CTRL, 32'h0000_0000);
        supply_lvl <= 8'h3a;
        repeat (8) @(posedge hclk);
        wr(`SIM_OFS_CTRL, 32'h0000_0003);
        rchk(`SIM_OFS_IRQ_STAT, 32'h0000_0000);
        rchk(`SIM_OFS_CTRL, 32'h0000_001a);
        supply_lvl <= 8'h33;
        repeat (10) @(posedge hclk);
        chk({31'h0, chip_reset}, 32'h0000_0000);
        supply_lvl <= 8'h30;
        wait_cr(1'b1);
        chk({31'h0, rst_pin_oe_n}, 32'h0000_0000);
        rchk(`SIM_OFS_IRQ_STAT, 32'h0000_0003);
        wr(`SIM_OFS_IRQ_STAT, 32'h0000_0007);
        supply_lvl <= 8'h33;
        repeat (20) @(posedge hclk);
        chk({31'h0, chip_reset}, 32'h0000_0001);
        supply_lvl <= 8'h3a;
        wait_cr(1'b0);
        rchk(`SIM_OFS_IRQ_STAT, 32'h0000_0000);
        illegal_op <= 1'b1;
        @(posedge hclk);
        illegal_op <= 1'b0;
        wait_cr(1'b1);
        wait_cr(1'b0);
        rchk(`SIM_OFS_IRQ_STAT, 32'h0000_0004);
        wr(8'h0c, 32'hffff_ffff);
        rchk(8'h0c, 32'h0000_0000);
        rchk(`SIM_OFS_IRQ_MASK, 32'h0000_0001);
        hresetn      <= 1'b0;
        opt_det_en   <= 1'b0;
        opt_level    <= 2'h2;
        opt_long_dly <= 1'b1;
        supply_lvl   <= 8'h00;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        wait_cr(1'b0);
        chk({31'h0, n >= POR_L}, 32'h0000_0001);
        rchk(`SIM_OFS_CTRL, 32'h0000_0060);
        wr(`SIM_OFS_CTRL, 32'h0000_0002);
        rchk(`SIM_OFS_IRQ_STAT, 32'h0000_0000);
        chk({29'h0, detector_on, threshold_sel}, 32'h0000_0002);
        end_of_test();
    end
endmodule // tb_top

`default_nettype wire
